// File: sspc_regs.svh
/*
 * register map, field positions, reset values and timing counts of the
 * switch source and pwm control block.
 * assumes a 100 MHz internal clock and one 16-bit host frame per access.
 */
// Summary of operation
// R1 - each 3-bit switch source field selects off, on, timer a/b or pwm a/b
// R2 - overcurrent or overtemperature on a switch clears its source field to off
// R3 - fail duty field sets third fail output duty: 20, 10, 5, 2.5 percent
// R4 - pin b config: 0xx third fail output, 100 off, 110 low-side, 111 high-side
// R5 - pin a config: 0xx second fail output, 100 off, 110 low-side, 111 high-side
// R6 - config 101 makes a pin a wake input with a 16 us static filter
// R7 - host using a filter time for cyclic sense assigns that timer to a switch
// R8 - pwm duty 0 is off, 255 fully on, otherwise on for N/255 of period
// R9 - host should not rely on tiny nonzero duty values like 1
// R10 - pwm frequency bit (bit 2 for b, bit 0 for a): 0 is 200 Hz, 1 is 400 Hz
// R11 - reserved bits ignore writes and read as zero
// R12 - pin config and duty registers clear on power-on or soft reset, kept on restart
// R13 - frequency register clears on power-on or soft reset, select bits kept on restart
// R14 - scratch byte clears only on power-on, kept across soft reset
// R15 - block logic never uses scratch byte; it survives fail-safe and restart
// R16 - scratch byte is accessible only in normal mode; other accesses are blocked
// R17 - each access is a 16-bit frame: 7-bit address, mode bit, then data byte
// R18 - pwm period from a counter on the internal clock, compared with duty
// R19 - a reserved source code leaves the switch off
`ifndef SSPC_REGS_SVH
`define SSPC_REGS_SVH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define SSPC_ADDR_SWITCH_SRC   7'h15
`define SSPC_ADDR_PIN_CFG      7'h17
`define SSPC_ADDR_PWM_A_DUTY   7'h18
`define SSPC_ADDR_PWM_B_DUTY   7'h19
`define SSPC_ADDR_PWM_FREQ     7'h1c
`define SSPC_ADDR_SCRATCH      7'h1e

// ----------------------------------------------------------------
// frame and field layout
// ----------------------------------------------------------------
`define SSPC_FRM_ADDR_MSB      6
`define SSPC_FRM_WRITE_BIT     7
`define SSPC_FRM_DATA_LSB      8
`define SSPC_SRC_C_LSB         0
`define SSPC_SRC_D_LSB         4
`define SSPC_PIN_A_LSB         0
`define SSPC_PIN_B_LSB         3
`define SSPC_FO_DUTY_LSB       6
`define SSPC_FREQ_A_BIT        0
`define SSPC_FREQ_B_BIT        2
`define SSPC_SWITCH_SRC_MASK   8'h77
`define SSPC_PWM_FREQ_MASK     8'h05
`define SSPC_RESET_VALUE       8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSPC_CLK_NS            10
`define SSPC_WAKE_FILT_NS      16000
`define SSPC_WAKE_FILT_CYC     ((`SSPC_WAKE_FILT_NS + `SSPC_CLK_NS - 1) / `SSPC_CLK_NS)
`define SSPC_PWM_200_NS        5000000
`define SSPC_PWM_200_CYC       (`SSPC_PWM_200_NS / `SSPC_CLK_NS)
`define SSPC_PWM_STEPS         255
`define SSPC_PWM_FULL          8'hff
`define SSPC_FO_PERIOD_CYC     400

`endif

// File: sspc_pkg.sv
/*
 * types of the switch source and pwm control block.
 * assumes nothing beyond the register header.
 */
package sspc_pkg;

    typedef enum logic [2:0] {
        SSPC_SRC_OFF     = 3'b000,
        SSPC_SRC_ON      = 3'b001,
        SSPC_SRC_TIMER_A = 3'b010,
        SSPC_SRC_TIMER_B = 3'b011,
        SSPC_SRC_PWM_A   = 3'b100,
        SSPC_SRC_PWM_B   = 3'b101,
        SSPC_SRC_RSVD_6  = 3'b110,
        SSPC_SRC_RSVD_7  = 3'b111
    } sspc_src_e;

    typedef enum logic [2:0] {
        SSPC_PIN_FAIL_0 = 3'b000,
        SSPC_PIN_FAIL_1 = 3'b001,
        SSPC_PIN_FAIL_2 = 3'b010,
        SSPC_PIN_FAIL_3 = 3'b011,
        SSPC_PIN_OFF    = 3'b100,
        SSPC_PIN_WAKE   = 3'b101,
        SSPC_PIN_LOW    = 3'b110,
        SSPC_PIN_HIGH   = 3'b111
    } sspc_pin_e;

endpackage : sspc_pkg

// File: sspc_pwm_if.sv
/*
 * link between the control top and one pwm generator.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface sspc_pwm_if;
    logic [7:0] duty;
    logic       freq_sel;
    logic       out;

    modport ctl (output duty, output freq_sel, input out);
    modport gen (input duty, input freq_sel, output out);
endinterface : sspc_pwm_if

// File: sspc_pwm.sv
/*
 * one 8-bit pwm generator, 255 steps per period, 200 Hz or 400 Hz.
 * assumes duty and frequency come from registers on the same clock.
 */
`timescale 1ns/1ps
`include "sspc_regs.svh"
module sspc_pwm #(
    parameter int PERIOD_200 = `SSPC_PWM_200_CYC,
    parameter int PRE_W      = 12
) (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    sspc_pwm_if.gen   pwm
);
    // tick length rounds down, so the period can be up to 254 cycles short (200 cycles at the default 200 Hz)
    localparam logic [PRE_W-1:0] TICK_200 = PRE_W'(PERIOD_200 / `SSPC_PWM_STEPS - 1);
    localparam logic [PRE_W-1:0] TICK_400 = PRE_W'(PERIOD_200 / (2 * `SSPC_PWM_STEPS) - 1);
    localparam logic [7:0]       LAST_STEP = 8'(`SSPC_PWM_STEPS - 1);

    logic [PRE_W-1:0] pre_r;
    logic [7:0]       step_r;
    logic             out_r;
    wire  [PRE_W-1:0] tick_lim  = pwm.freq_sel ? TICK_400 : TICK_200;  // R10
    wire              tick      = (pre_r >= tick_lim);
    wire              step_wrap = (step_r == LAST_STEP);
    wire              out_nxt   = (pwm.duty == `SSPC_PWM_FULL) | (step_r < pwm.duty);  // R8

    // R18
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            pre_r  <= '0;
            step_r <= 8'h00;
            out_r  <= 1'b0;
        end else begin
            pre_r  <= tick ? '0 : pre_r + 1'b1;
            if (tick) begin
                step_r <= step_wrap ? 8'h00 : step_r + 8'h01;
            end
            out_r  <= out_nxt;
        end
    end

    assign pwm.out = out_r;

    AST_PWM_ZERO_OFF: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (pwm.duty == 8'h00) [*2] |-> !out_r)  // R8
        else $error("pwm drives output with zero duty");
    AST_PWM_FULL_ON: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (pwm.duty == `SSPC_PWM_FULL) |=> out_r)  // R8
        else $error("pwm not on with full duty");
    AST_PWM_STEP_RANGE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        step_r <= LAST_STEP)  // R18
        else $error("pwm step counter out of range");
    COV_PWM_WRAP: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
        tick && step_wrap);

endmodule : sspc_pwm

// File: sspc_top.sv
/*
 * switch source select, pin function, pwm and scratch registers.
 * assumes host frames arrive already deserialised on the internal clock,
 * and that fault, mode, timer and fail inputs are on the same clock.
 * pin inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
`include "sspc_regs.svh"
module sspc_top #(
    parameter int PWM_PERIOD_200 = `SSPC_PWM_200_CYC,
    parameter int FO_PERIOD      = `SSPC_FO_PERIOD_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_soft_reset,
    input  wire logic        i_restart_entry,
    input  wire logic        i_normal_mode,
    input  wire logic        i_frame_valid,
    input  wire logic [15:0] i_frame,
    input  wire logic        i_switch_c_fault,
    input  wire logic        i_switch_d_fault,
    input  wire logic        i_timer_a,
    input  wire logic        i_timer_b,
    input  wire logic        i_fail_output_second,
    input  wire logic        i_fail_third_active,
    input  wire logic [1:0]  i_pin_in,
    output logic             o_rd_valid_r,
    output logic [7:0]       o_rd_data_r,
    output logic             o_switch_c_on_r,
    output logic             o_switch_d_on_r,
    output logic [1:0]       o_pin_out_r,
    output logic [1:0]       o_pin_oe_r,
    output logic [1:0]       o_pin_wake_r
);
    localparam int          WAKE_W   = $clog2(`SSPC_WAKE_FILT_CYC + 1);
    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(`SSPC_WAKE_FILT_CYC - 1);
    localparam int          FO_W     = $clog2(FO_PERIOD + 1);

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    wire [6:0] addr   = i_frame[`SSPC_FRM_ADDR_MSB:0];  // R17
    wire [7:0] wdata  = i_frame[15:`SSPC_FRM_DATA_LSB];
    wire       wr     = i_frame_valid & i_frame[`SSPC_FRM_WRITE_BIT];
    wire       wr_src = wr & (addr == `SSPC_ADDR_SWITCH_SRC);
    wire       wr_pin = wr & (addr == `SSPC_ADDR_PIN_CFG);
    wire       wr_pa  = wr & (addr == `SSPC_ADDR_PWM_A_DUTY);
    wire       wr_pb  = wr & (addr == `SSPC_ADDR_PWM_B_DUTY);
    wire       wr_frq = wr & (addr == `SSPC_ADDR_PWM_FREQ);
    // scratch is closed outside normal mode
    wire       scr_ok = (addr == `SSPC_ADDR_SCRATCH) & i_normal_mode;  // R16
    wire       wr_scr = wr & scr_ok;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] src_r, pin_r, duty_a_r, duty_b_r, freq_r, scratch_r;
    logic [7:0] src_nxt;

    // fault clear wins over a host write in the same cycle: a tripped switch must stay off
    always_comb begin
        src_nxt = wr_src ? (wdata & `SSPC_SWITCH_SRC_MASK) : src_r;  // R11
        if (i_switch_c_fault) begin
            src_nxt[`SSPC_SRC_C_LSB +: 3] = 3'h0;  // R2
        end
        if (i_switch_d_fault) begin
            src_nxt[`SSPC_SRC_D_LSB +: 3] = 3'h0;  // R2
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_soft_reset || i_restart_entry) begin
            src_r <= `SSPC_RESET_VALUE;
        end else begin
            src_r <= src_nxt;
        end
    end

    // restart entry leaves these untouched
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || i_soft_reset) begin
            pin_r    <= `SSPC_RESET_VALUE;  // R12
            duty_a_r <= `SSPC_RESET_VALUE;
            duty_b_r <= `SSPC_RESET_VALUE;
            freq_r   <= `SSPC_RESET_VALUE;  // R13
        end else begin
            if (wr_pin) pin_r <= wdata;
            if (wr_pa) duty_a_r <= wdata;
            if (wr_pb) duty_b_r <= wdata;
            if (wr_frq) freq_r <= wdata & `SSPC_PWM_FREQ_MASK;  // R11
        end
    end

    // only power-on clears it; no block logic reads it
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            scratch_r <= `SSPC_RESET_VALUE;  // R14
        end else if (wr_scr) begin
            scratch_r <= wdata;  // R15
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    wire [7:0] rd_mux =
        (addr == `SSPC_ADDR_SWITCH_SRC) ? src_r    :
        (addr == `SSPC_ADDR_PIN_CFG)    ? pin_r    :
        (addr == `SSPC_ADDR_PWM_A_DUTY) ? duty_a_r :
        (addr == `SSPC_ADDR_PWM_B_DUTY) ? duty_b_r :
        (addr == `SSPC_ADDR_PWM_FREQ)   ? freq_r   :
        scr_ok                          ? scratch_r : 8'h00;  // R16

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_rd_valid_r <= 1'b0;
            o_rd_data_r  <= 8'h00;
        end else begin
            o_rd_valid_r <= i_frame_valid;
            o_rd_data_r  <= i_frame_valid ? rd_mux : o_rd_data_r;
        end
    end

    // ------------------------------------------------------------
    // pwm generators
    // ------------------------------------------------------------
    wire  [1:0] pwm_out;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pwm
            sspc_pwm_if pif ();
            assign pif.duty     = (g == 0) ? duty_a_r : duty_b_r;
            assign pif.freq_sel = freq_r[(g == 0) ? `SSPC_FREQ_A_BIT : `SSPC_FREQ_B_BIT];  // R10
            assign pwm_out[g]   = pif.out;
            sspc_pwm #(
                .PERIOD_200 (PWM_PERIOD_200)
            ) u_pwm (
                .i_mclk    (i_mclk),
                .i_reset_n (i_reset_n),
                .pwm       (pif.gen)
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // switch drive
    // ------------------------------------------------------------
    // timers are passed in, not read from the ports inside, so that the continuous
    // assignments below re-evaluate when a timer level moves
    function automatic logic src_level(input logic [2:0] code, input logic [1:0] tm,
                                       input logic [1:0] pw);
        unique case (sspc_pkg::sspc_src_e'(code))  // R1
            sspc_pkg::SSPC_SRC_OFF:     src_level = 1'b0;
            sspc_pkg::SSPC_SRC_ON:      src_level = 1'b1;
            sspc_pkg::SSPC_SRC_TIMER_A: src_level = tm[0];
            sspc_pkg::SSPC_SRC_TIMER_B: src_level = tm[1];
            sspc_pkg::SSPC_SRC_PWM_A:   src_level = pw[0];  // R18
            sspc_pkg::SSPC_SRC_PWM_B:   src_level = pw[1];
            default:                    src_level = 1'b0;  // R19
        endcase
    endfunction : src_level

    wire [1:0] timers  = {i_timer_b, i_timer_a};
    wire sw_c_nxt = src_level(src_r[`SSPC_SRC_C_LSB +: 3], timers, pwm_out);
    wire sw_d_nxt = src_level(src_r[`SSPC_SRC_D_LSB +: 3], timers, pwm_out);

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_switch_c_on_r <= 1'b0;
            o_switch_d_on_r <= 1'b0;
        end else begin
            o_switch_c_on_r <= sw_c_nxt;
            o_switch_d_on_r <= sw_d_nxt;
        end
    end

    // ------------------------------------------------------------
    // third fail output duty
    // ------------------------------------------------------------
    logic [FO_W-1:0] fo_cnt_r;
    logic            fo3_r;
    wire  [1:0]      fo_duty = pin_r[`SSPC_FO_DUTY_LSB +: 2];
    wire  [FO_W-1:0] fo_on   = (fo_duty == 2'h0) ? FO_W'(FO_PERIOD / 5)  :
                               (fo_duty == 2'h1) ? FO_W'(FO_PERIOD / 10) :
                               (fo_duty == 2'h2) ? FO_W'(FO_PERIOD / 20) :
                                                   FO_W'(FO_PERIOD / 40);  // R3
    wire             fo_wrap = (fo_cnt_r == FO_W'(FO_PERIOD - 1));

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            fo_cnt_r <= '0;
            fo3_r    <= 1'b0;
        end else begin
            fo_cnt_r <= fo_wrap ? '0 : fo_cnt_r + 1'b1;
            fo3_r    <= i_fail_third_active & (fo_cnt_r < fo_on);  // R3
        end
    end

    // ------------------------------------------------------------
    // general pins
    // ------------------------------------------------------------
    wire [1:0] fail_src = {fo3_r, i_fail_output_second};
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic [1:0]        sync_r;
            logic [WAKE_W-1:0] flt_cnt_r;
            wire  [2:0] cfg = pin_r[((g == 0) ? `SSPC_PIN_A_LSB : `SSPC_PIN_B_LSB) +: 3];  // R4 R5
            wire  is_fail  = ~cfg[2];
            wire  is_wake  = (cfg == sspc_pkg::SSPC_PIN_WAKE);  // R6
            wire  is_low   = (cfg == sspc_pkg::SSPC_PIN_LOW);
            wire  is_high  = (cfg == sspc_pkg::SSPC_PIN_HIGH);
            wire  differ   = (sync_r[1] != o_pin_wake_r[g]);
            wire  accept   = is_wake & differ & (flt_cnt_r == WAKE_LAST);

            always_ff @(posedge i_mclk) begin
                if (!i_reset_n) begin
                    sync_r          <= 2'b00;
                    flt_cnt_r       <= '0;
                    o_pin_wake_r[g] <= 1'b0;
                    o_pin_out_r[g]  <= 1'b0;
                    o_pin_oe_r[g]   <= 1'b0;
                end else begin
                    sync_r          <= {sync_r[0], i_pin_in[g]};
                    flt_cnt_r       <= (is_wake & differ & !accept) ? flt_cnt_r + 1'b1 : '0;  // R6
                    if (accept) o_pin_wake_r[g] <= sync_r[1];
                    o_pin_out_r[g]  <= is_high | (is_fail & fail_src[g]);  // R4 R5
                    o_pin_oe_r[g]   <= is_fail | is_low | is_high;
                end
            end

            AST_WAKE_FILTER: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
                $changed(o_pin_wake_r[g]) |-> $past(flt_cnt_r) == WAKE_LAST)  // R6
                else $error("wake level accepted before filter time");
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    AST_FAULT_CLEAR_C: assert property (i_switch_c_fault |=> src_r[2:0] == 3'h0)  // R2
        else $error("switch c source not cleared on fault");
    AST_FAULT_CLEAR_D: assert property (i_switch_d_fault |=> src_r[6:4] == 3'h0)  // R2
        else $error("switch d source not cleared on fault");
    AST_RSVD_OFF: assert property (src_r[2:1] == 2'b11 |=> !o_switch_c_on_r)  // R19
        else $error("reserved source drove switch c");
    AST_SRC_ON: assert property (src_r[2:0] == 3'h1 |=> o_switch_c_on_r)  // R1
        else $error("switch c not on for source on");
    AST_RSVD_ZERO: assert property (((freq_r & ~`SSPC_PWM_FREQ_MASK) == 8'h00)
        && ((src_r & ~`SSPC_SWITCH_SRC_MASK) == 8'h00))  // R11
        else $error("reserved bit set");
    AST_SCRATCH_BLOCKED: assert property (!i_normal_mode |=> $stable(scratch_r))  // R16
        else $error("scratch changed outside normal mode");
    AST_SCRATCH_SOFT: assert property (i_soft_reset && !wr_scr |=> $stable(scratch_r))  // R14
        else $error("scratch lost on soft reset");
    AST_SOFT_CLEAR: assert property (i_soft_reset |=> pin_r == 8'h00 && duty_a_r == 8'h00
        && freq_r == 8'h00)  // R12
        else $error("control not cleared on soft reset");
    AST_RESTART_KEEP: assert property (i_restart_entry && !i_soft_reset && !wr
        |=> $stable(pin_r) && $stable(freq_r) && $stable(duty_b_r) && src_r == 8'h00)  // R13
        else $error("restart entry changed kept registers");
    AST_READ_ANSWER: assert property (i_frame_valid |=> o_rd_valid_r ##1 !o_rd_valid_r
        or i_frame_valid)  // R17
        else $error("read answer missing");

    COV_PWM_A_ON_C: cover property (src_r[2:0] == 3'h4 ##1 o_switch_c_on_r);
    COV_FAULT_WRITE: cover property (i_switch_c_fault && wr_src);
    COV_WAKE: cover property (o_pin_wake_r[0] && pin_r[2:0] == 3'h5);

endmodule : sspc_top

// File: sspc_host_model.sv
/*
 * host model: sends one 16-bit frame per access and takes the answer.
 * assumes the block answers one cycle after the frame is taken.
 */
`timescale 1ns/1ps
module sspc_host_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rd_valid,
    input  wire logic [7:0]  i_rd_data,
    output logic             o_frame_valid,
    output logic [15:0]      o_frame
);
    initial begin
        o_frame_valid = 1'b0;
        o_frame       = 16'h0000;
    end

    // ------------------------------------------------------------
    // one access
    // ------------------------------------------------------------
    task automatic access(input logic [6:0] addr, input logic wr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
        @(negedge i_mclk);
        o_frame_valid = 1'b1;
        o_frame       = {wdata, wr, addr};
        @(negedge i_mclk);
        o_frame_valid = 1'b0;
        // stale bits inverted so nothing can lean on a released frame
        o_frame       = ~o_frame;
        rdata         = i_rd_valid ? i_rd_data : 8'hxx;
    endtask : access
endmodule : sspc_host_model

// File: sspc_top_test.sv
/*
 * self-checking bench of the switch source and pwm control block.
 * assumes frames come from the host model and a shortened pwm period.
 */
`timescale 1ns/1ps
`include "sspc_regs.svh"
module sspc_top_test;
    localparam int PERIOD = 2550;
    logic        mclk, reset_n, soft_reset, restart_entry, normal_mode, frame_valid;
    logic        fault_c, fault_d, timer_a, timer_b, fail_second, fail_third;
    logic [15:0] frame;
    logic [1:0]  pin_in, pin_out, pin_oe, pin_wake;
    logic        rd_valid, sw_c, sw_d;
    logic [7:0]  rd_data, rdata, expv;
    logic [6:0]  addrs [6];
    logic [7:0]  masks [6];
    int          n_mismatch, comparisons, cycles, cnt;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    sspc_top #(.PWM_PERIOD_200(PERIOD), .FO_PERIOD(40)) dut (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_soft_reset(soft_reset),
        .i_restart_entry(restart_entry), .i_normal_mode(normal_mode),
        .i_frame_valid(frame_valid), .i_frame(frame), .i_switch_c_fault(fault_c),
        .i_switch_d_fault(fault_d), .i_timer_a(timer_a), .i_timer_b(timer_b),
        .i_fail_output_second(fail_second), .i_fail_third_active(fail_third),
        .i_pin_in(pin_in), .o_rd_valid_r(rd_valid), .o_rd_data_r(rd_data),
        .o_switch_c_on_r(sw_c), .o_switch_d_on_r(sw_d), .o_pin_out_r(pin_out),
        .o_pin_oe_r(pin_oe), .o_pin_wake_r(pin_wake)
    );

    sspc_host_model host (
        .i_mclk(mclk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
        .o_frame_valid(frame_valid), .o_frame(frame)
    );

    // ------------------------------------------------------------
    // checks and accesses
    // ------------------------------------------------------------
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_count(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            n_mismatch++;
            $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask : check_count

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.access(a, 1'b1, d, rdata);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        host.access(a, 1'b0, 8'h00, rdata);
        check_byte(rdata, e);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    // counts high cycles of switch c, switch d or pin b over n cycles
    task automatic measure(input int n, input int s);
        cnt = 0;
        repeat (n) begin
            @(negedge mclk);
            if ((s == 0 ? sw_c : s == 1 ? sw_d : pin_out[1] & pin_oe[1]) === 1'b1) cnt++;
        end
    endtask : measure

    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, soft_reset, restart_entry, fault_c, fault_d, timer_a, timer_b} = 7'h00;
        {fail_second, fail_third, pin_in} = 4'h0;
        normal_mode = 1'b1;
        addrs = '{`SSPC_ADDR_SWITCH_SRC, `SSPC_ADDR_PIN_CFG, `SSPC_ADDR_PWM_A_DUTY,
                  `SSPC_ADDR_PWM_B_DUTY, `SSPC_ADDR_PWM_FREQ, `SSPC_ADDR_SCRATCH};
        masks = '{8'h77, 8'hff, 8'hff, 8'hff, 8'h05, 8'hff};
        idle(5);
        reset_n = 1'b1;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        foreach (addrs[i]) wr(addrs[i], 8'hff);
        foreach (addrs[i]) rd(addrs[i], masks[i]);
        wr(7'h20, 8'hff);
        rd(7'h20, 8'h00);
        // every source code, timers and duties swapped on the second pass
        for (int p = 0; p < 2; p++) begin
            timer_a = (p == 0);
            timer_b = (p == 1);
            wr(`SSPC_ADDR_PWM_A_DUTY, p ? 8'h00 : 8'hff);
            wr(`SSPC_ADDR_PWM_B_DUTY, p ? 8'hff : 8'h00);
            expv = p ? 8'h2a : 8'h16;
            for (int c = 0; c < 8; c++) begin
                wr(`SSPC_ADDR_SWITCH_SRC, {1'b0, c[2:0], 1'b0, c[2:0]});
                idle(4);
                check_byte({6'h00, sw_d, sw_c}, {6'h00, expv[c], expv[c]});
            end
        end
        wr(`SSPC_ADDR_SWITCH_SRC, 8'h11);
        fault_c = 1'b1;
        idle(3);
        fault_c = 1'b0;
        check_byte({6'h00, sw_d, sw_c}, 8'h02);
        rd(`SSPC_ADDR_SWITCH_SRC, 8'h10);
        fault_d = 1'b1;
        idle(3);
        fault_d = 1'b0;
        check_byte({6'h00, sw_d, sw_c}, 8'h00);
        // pin modes, packed as {oe, out and oe}
        fail_second = 1'b1;
        expv = 8'h37;
        foreach (masks[i]) if (i < 4) begin
            wr(`SSPC_ADDR_PIN_CFG, i == 0 ? 8'h37 : i == 1 ? 8'h3e : i == 2 ? 8'h24 : 8'h20);
            idle(2);
            check_byte({4'h0, pin_oe, pin_out & pin_oe},
                       i == 0 ? 8'h0d : i == 1 ? 8'h0e : i == 2 ? 8'h00 : 8'h05);
        end
        fail_third = 1'b1;
        for (int d = 0; d < 4; d++) begin
            wr(`SSPC_ADDR_PIN_CFG, {d[1:0], 6'h04});
            idle(3);
            measure(40, 2);
            check_count(cnt, 8 >> d);
        end
        // wake filter: a short pulse is dropped, a long level is taken
        wr(`SSPC_ADDR_PIN_CFG, 8'h05);
        pin_in[0] = 1'b1;
        idle(1000);
        pin_in[0] = 1'b0;
        idle(700);
        check_byte({6'h00, pin_oe[0], pin_wake[0]}, 8'h00);
        pin_in[0] = 1'b1;
        idle(1590);
        check_byte({7'h00, pin_wake[0]}, 8'h00);
        idle(20);
        check_byte({7'h00, pin_wake[0]}, 8'h01);
        // duty ratios, mid-range values only since tiny ones are not realisable
        wr(`SSPC_ADDR_SWITCH_SRC, 8'h54);
        wr(`SSPC_ADDR_PWM_A_DUTY, 8'h80);
        wr(`SSPC_ADDR_PWM_B_DUTY, 8'h40);
        for (int f = 0; f < 2; f++) begin
            wr(`SSPC_ADDR_PWM_FREQ, f ? 8'h05 : 8'h00);
            idle(PERIOD);
            measure(PERIOD >> f, 0);
            check_count(cnt, 128 * ((PERIOD / 255) >> f));
            measure(PERIOD >> f, 1);
            check_count(cnt, 64 * ((PERIOD / 255) >> f));
        end
        // restart, soft reset, mode gating and power-on
        wr(`SSPC_ADDR_SCRATCH, 8'h5a);
        wr(`SSPC_ADDR_PIN_CFG, 8'h12);
        wr(`SSPC_ADDR_PWM_A_DUTY, 8'h34);
        wr(`SSPC_ADDR_PWM_FREQ, 8'h05);
        wr(`SSPC_ADDR_SWITCH_SRC, 8'h11);
        restart_entry = 1'b1;
        idle(1);
        restart_entry = 1'b0;
        rd(`SSPC_ADDR_SWITCH_SRC, 8'h00);
        rd(`SSPC_ADDR_PIN_CFG, 8'h12);
        rd(`SSPC_ADDR_PWM_A_DUTY, 8'h34);
        rd(`SSPC_ADDR_PWM_FREQ, 8'h05);
        rd(`SSPC_ADDR_SCRATCH, 8'h5a);
        soft_reset = 1'b1;
        idle(1);
        soft_reset = 1'b0;
        rd(`SSPC_ADDR_PIN_CFG, 8'h00);
        rd(`SSPC_ADDR_PWM_A_DUTY, 8'h00);
        rd(`SSPC_ADDR_PWM_FREQ, 8'h00);
        rd(`SSPC_ADDR_SCRATCH, 8'h5a);
        normal_mode = 1'b0;
        wr(`SSPC_ADDR_SCRATCH, 8'h33);
        rd(`SSPC_ADDR_SCRATCH, 8'h00);
        normal_mode = 1'b1;
        rd(`SSPC_ADDR_SCRATCH, 8'h5a);
        reset_n = 1'b0;
        idle(2);
        reset_n = 1'b1;
        rd(`SSPC_ADDR_SCRATCH, 8'h00);
        give_verdict();
    end
endmodule : sspc_top_test
